// ---- hw/pca_alarm_supervisor.sv ----
// Decided for this implementation: the plain strobed port and the address map.
`default_nettype none
module pca_alarm_supervisor #(
	parameter int MS_CYCLES = pca_pkg::MS_CYCLES_DFLT
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_we,
	input  wire logic             reg_re,
	output logic      [31:0]      reg_rdata,
	input  wire logic             meas_strobe,
	input  wire logic             freq_strobe,
	input  wire logic [2:0]       supply_present,
	input  wire logic [2:0][15:0] line_v,
	input  wire logic [2:0][15:0] load_v,
	input  wire logic [2:0][9:0]  load_i_pct,
	input  wire logic [2:0][15:0] load_z,
	input  wire logic [2:0][7:0]  sink_temp,
	input  wire logic [15:0]      mains_freq,
	input  wire logic             rail_24v_ok,
	input  wire logic             loop_demand,
	input  wire logic [7:0]       loop_error_pct,
	input  wire logic [31:0]      requested_shed_power,
	input  wire logic [31:0]      total_demand_power,
	input  wire logic [31:0]      real_delivered_power,
	input  wire logic [3:0][7:0]  duty_in,
	output logic      [3:0][7:0]  duty_out,
	output logic      [2:0]       fire_enable,
	output logic      [2:0]       standby,
	output logic      [8:0]       alarm_active,
	output logic      [8:0]       alarm_latched
);
	localparam int MS_W = $clog2(MS_CYCLES);

	logic [6:0]  stop_en_q;
	logic [8:0]  latch_en_q;
	logic [31:0] lim0_q;
	logic [31:0] lim1_q;
	logic [31:0] cfg_q;
	logic [31:0] shed_q;
	logic [31:0] nom_q;
	logic [31:0] rdata_q;
	logic [8:0]  ack_p;
	logic        impedance_reference_capture;
	logic [7:0]  supply_dip_limit;
	logic [7:0]  sink_warning_temperature;
	logic [7:0]  line_high_limit;
	logic [7:0]  line_low_limit;
	logic [8:0]  load_current_warning_limit;
	logic [7:0]  sustained_overcurrent_limit;
	logic [4:0]  repeat_count;
	logic [2:0]  partial_failure_divisor;
	logic [15:0] chop_window;
	logic [7:0]  phase_imbalance_limit;
	logic [1:0]  phase_count;
	logic        lm_master;
	logic        base60;
	logic        repeated_overcurrent_mode;
	logic [15:0] nominal_line_voltage;
	logic [15:0] integral_ms;

	assign ack_p = (reg_we && reg_addr == pca_pkg::REG_ACK) ? reg_wdata[8:0] : 9'h000;
	assign impedance_reference_capture = reg_we && reg_addr == pca_pkg::REG_CAPTURE
		&& reg_wdata[0];
	assign supply_dip_limit = lim0_q[pca_pkg::L0_DIP +: 8];
	assign sink_warning_temperature = lim0_q[pca_pkg::L0_PRE +: 8];
	assign line_high_limit = lim0_q[pca_pkg::L0_HIGH +: 8];
	assign line_low_limit = lim0_q[pca_pkg::L0_LOW +: 8];
	assign load_current_warning_limit = lim1_q[pca_pkg::L1_WARN +: 9];
	assign sustained_overcurrent_limit = lim1_q[pca_pkg::L1_SUST +: 8];
	assign repeat_count = lim1_q[pca_pkg::L1_CNT +: 5];
	assign partial_failure_divisor = lim1_q[pca_pkg::L1_DIV +: 3];
	assign chop_window = cfg_q[pca_pkg::CF_WIN +: 16];
	assign phase_imbalance_limit = cfg_q[pca_pkg::CF_IMB +: 8];
	assign phase_count = cfg_q[pca_pkg::CF_PHASES +: 2];
	assign lm_master = cfg_q[pca_pkg::CF_MASTER];
	assign base60 = cfg_q[pca_pkg::CF_BASE60];
	assign repeated_overcurrent_mode = cfg_q[pca_pkg::CF_REPEAT];
	assign nominal_line_voltage = nom_q[pca_pkg::NM_VNOM +: 16];
	assign integral_ms = nom_q[pca_pkg::NM_TI +: 16];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stop_en_q  <= pca_pkg::STOP_EN_RST;
			latch_en_q <= pca_pkg::LATCH_EN_RST;
			lim0_q     <= pca_pkg::LIM0_RST;
			lim1_q     <= pca_pkg::LIM1_RST;
			cfg_q      <= pca_pkg::CFG_RST;
			shed_q     <= pca_pkg::SHED_RST;
			nom_q      <= pca_pkg::NOM_RST;
		end else if (reg_we) begin
			case (reg_addr)
				pca_pkg::REG_STOP_EN: stop_en_q <= reg_wdata[6:0];
				pca_pkg::REG_LATCH_EN: latch_en_q <= reg_wdata[8:0];
				pca_pkg::REG_LIM0: lim0_q <= reg_wdata;
				pca_pkg::REG_LIM1: lim1_q <= reg_wdata;
				pca_pkg::REG_CFG: cfg_q <= reg_wdata;
				pca_pkg::REG_SHED: shed_q <= reg_wdata;
				pca_pkg::REG_NOM: nom_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// millisecond and second time base
	logic [MS_W-1:0] ms_cnt_q;
	logic            ms_tick;
	logic [9:0]      sub_ms_q;
	logic [31:0]     sec_q;
	assign ms_tick = ms_cnt_q == MS_W'(MS_CYCLES - 1);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ms_cnt_q <= '0;
			sub_ms_q <= 10'h000;
			sec_q    <= 32'h0;
		end else begin
			ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
			if (ms_tick) begin
				if (sub_ms_q == 10'(pca_pkg::SEC_MS - 1)) begin
					sub_ms_q <= 10'h000;
					sec_q    <= sec_q + 32'h1;
				end else begin
					sub_ms_q <= sub_ms_q + 10'h001;
				end
			end
		end
	end

	// rail monitor is a pin from the power board
	logic rail_s1_q;
	logic rail_s2_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rail_s1_q <= 1'b0;
			rail_s2_q <= 1'b0;
		end else begin
			rail_s1_q <= rail_24v_ok;
			rail_s2_q <= rail_s1_q;
		end
	end

	// per-phase measurement checks
	logic [2:0]  dip_drop;
	logic [2:0]  dip_back;
	logic [2:0]  mv_now;
	logic [2:0]  tlf_now;
	logic [2:0]  plf_now;
	logic [9:0]  i_max;
	logic [9:0]  i_min;
	logic [7:0]  t_max;
	logic [15:0] prev_v_q [3];
	logic [15:0] dip_ref_q [3];
	logic [15:0] zref_q [3];
	logic [2:0]  over_temp_q;
	logic [2:0]  dip_q;
	logic [2:0]  mains_volt_q;
	logic [2:0]  total_load_loss_alarm_q;
	logic [2:0]  partial_load_loss_alarm_q;

	always_comb begin
		i_max = 10'h000;
		i_min = 10'h3ff;
		t_max = 8'h00;
		for (int p = 0; p < pca_pkg::PH_N; p++) begin
			dip_drop[p] = line_v[p] < prev_v_q[p] && 24'(prev_v_q[p] - line_v[p]) * 24'h64
				> 24'(supply_dip_limit) * 24'(prev_v_q[p]);
			dip_back[p] = 24'(line_v[p]) * 24'h64
				>= 24'(dip_ref_q[p]) * 24'(8'h64 - supply_dip_limit);
			mv_now[p] = supply_present[p]
				&& (25'(line_v[p]) * 25'h64 > 25'(line_high_limit) * 25'(nominal_line_voltage)
				|| 25'(line_v[p]) * 25'h64 < 25'(line_low_limit) * 25'(nominal_line_voltage));
			tlf_now[p] = 25'(load_v[p]) * 25'h64 > 25'(nominal_line_voltage) * pca_pkg::TLF_V_PCT
				&& load_i_pct[p] < pca_pkg::TLF_I_PCT;
			plf_now[p] = zref_q[p] != 16'h0000
				&& 20'(load_z[p]) * 20'(partial_failure_divisor - 3'h1)
				>= 20'(zref_q[p]) * 20'(partial_failure_divisor);
			if (load_i_pct[p] > i_max)
				i_max = load_i_pct[p];
			if (load_i_pct[p] < i_min)
				i_min = load_i_pct[p];
			if (sink_temp[p] > t_max)
				t_max = sink_temp[p];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			over_temp_q               <= 3'h0;
			dip_q                     <= 3'h0;
			mains_volt_q              <= 3'h0;
			total_load_loss_alarm_q   <= 3'h0;
			partial_load_loss_alarm_q <= 3'h0;
			for (int p = 0; p < pca_pkg::PH_N; p++) begin
				prev_v_q[p]  <= 16'h0000;
				dip_ref_q[p] <= 16'h0000;
				zref_q[p]    <= 16'h0000;
			end
		end else begin
			for (int p = 0; p < pca_pkg::PH_N; p++) begin
				if (sink_temp[p] >= pca_pkg::OT_TRIP_C)
					over_temp_q[p] <= 1'b1;
				else if (sink_temp[p] <= pca_pkg::OT_CLEAR_C)
					over_temp_q[p] <= 1'b0;
				if (impedance_reference_capture)
					zref_q[p] <= load_z[p];
				if (meas_strobe) begin
					prev_v_q[p] <= line_v[p];
					if (!dip_q[p] && dip_drop[p]) begin
						dip_q[p]     <= 1'b1;
						dip_ref_q[p] <= prev_v_q[p];
					end else if (dip_q[p] && dip_back[p]) begin
						dip_q[p] <= 1'b0;
					end
					mains_volt_q[p]              <= mv_now[p];
					total_load_loss_alarm_q[p]   <= tlf_now[p];
					partial_load_loss_alarm_q[p] <= plf_now[p] && !tlf_now[p];
				end
			end
		end
	end

	// mains frequency
	logic [15:0] prev_f_q;
	logic        freq_q;
	logic [15:0] f_base;
	logic [15:0] f_delta;
	logic        freq_bad;
	assign f_base = base60 ? pca_pkg::F_BASE60 : pca_pkg::F_BASE50;
	assign f_delta = mains_freq > prev_f_q ? mains_freq - prev_f_q : prev_f_q - mains_freq;
	assign freq_bad = mains_freq < pca_pkg::F_MIN || mains_freq > pca_pkg::F_MAX
		|| (prev_f_q != 16'h0000
		&& (30'(f_delta) * 30'h2710 > 30'(f_base) * pca_pkg::F_BASE_PER_10K
		|| 30'(f_delta) * 30'h3e8 > 30'(prev_f_q) * pca_pkg::F_LAST_PER_1K));
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_f_q <= 16'h0000;
			freq_q   <= 1'b1;
		end else if (freq_strobe) begin
			prev_f_q <= mains_freq;
			freq_q   <= freq_bad;
		end
	end

	// system alarms and standby
	logic       multi;
	logic [2:0] supply_absent_alarm;
	logic [2:0] sys_ph;
	logic       sys_global;
	logic [2:0] standby_ph;
	assign multi = phase_count >= 2'h2;
	assign supply_absent_alarm = ~supply_present;
	assign sys_ph = supply_absent_alarm | over_temp_q | dip_q;
	assign sys_global = freq_q || !rail_s2_q;
	assign standby_ph = multi ? {3{(|sys_ph) | sys_global}} : sys_ph | {3{sys_global}};

	// overcurrent chop-off: crossings are time-stamped in seconds
	logic                  over;
	logic                  over_q;
	logic                  over_rise;
	logic [12:0]           sus_ms_q;
	logic                  sust_hit;
	logic [6:0]            pause_ms_q;
	logic [3:0]            wp_q;
	logic [3:0]            old_idx;
	logic [15:0]           ts_valid_q;
	logic [31:0]           ts_q [16];
	logic                  exceed;
	logic                  lock_set;
	pca_pkg::pca_chop_e    chop_q;
	assign over = i_max >= 10'(sustained_overcurrent_limit);
	assign over_rise = over && !over_q;
	// a count of 16 wraps to the oldest slot
	assign old_idx = wp_q - repeat_count[3:0];
	assign exceed = repeated_overcurrent_mode && ts_valid_q[old_idx]
		&& (sec_q - ts_q[old_idx]) < 32'(chop_window);
	assign sust_hit = sus_ms_q > pca_pkg::CHOP_SUSTAIN_MS;
	assign lock_set = sust_hit || (over_rise && exceed);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			over_q     <= 1'b0;
			sus_ms_q   <= 13'h0000;
			wp_q       <= 4'h0;
			ts_valid_q <= 16'h0000;
			for (int k = 0; k < 16; k++)
				ts_q[k] <= 32'h0;
		end else begin
			over_q <= over;
			if (!over)
				sus_ms_q <= 13'h0000;
			else if (ms_tick && !sust_hit)
				sus_ms_q <= sus_ms_q + 13'h0001;
			if (over_rise) begin
				ts_q[wp_q]       <= sec_q;
				ts_valid_q[wp_q] <= 1'b1;
				wp_q             <= wp_q + 4'h1;
			end
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			chop_q     <= pca_pkg::CH_RUN;
			pause_ms_q <= 7'h00;
		end else begin
			case (chop_q)
				pca_pkg::CH_RUN: begin
					if (lock_set) begin
						chop_q <= pca_pkg::CH_LOCK;
					end else if (over_rise) begin
						chop_q     <= pca_pkg::CH_PAUSE;
						pause_ms_q <= 7'h00;
					end
				end
				pca_pkg::CH_PAUSE: begin
					if (lock_set)
						chop_q <= pca_pkg::CH_LOCK;
					else if (ms_tick && pause_ms_q == pca_pkg::CHOP_PAUSE_MS - 7'h01)
						chop_q <= pca_pkg::CH_RUN;
					else if (ms_tick)
						pause_ms_q <= pause_ms_q + 7'h01;
				end
				pca_pkg::CH_LOCK: begin
					// acknowledge only counts once current is below the limit
					if (ack_p[pca_pkg::A_CHOP] && !over)
						chop_q <= pca_pkg::CH_RUN;
				end
				default: chop_q <= pca_pkg::CH_RUN;
			endcase
		end
	end

	// remaining process and indication alarms
	logic [17:0] loop_ms_q;
	logic        loop_hit;
	logic        pre_q;
	logic        phase_imbalance_alarm_q;
	logic        ovc_q;
	logic        over_shed_q;
	logic [6:0]  ratio_q;
	logic [6:0]  coeff [4];
	logic [3:0][7:0] duty_out_q;
	assign loop_hit = loop_ms_q >= 18'(integral_ms) * 18'(pca_pkg::LOOP_TI_MULT);
	always_comb begin
		for (int c = 0; c < pca_pkg::CH_N; c++)
			coeff[c] = shed_q[c*8 +: 7] > ratio_q ? shed_q[c*8 +: 7] : ratio_q;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			loop_ms_q               <= 18'h00000;
			pre_q                   <= 1'b0;
			phase_imbalance_alarm_q <= 1'b0;
			ovc_q                   <= 1'b0;
			over_shed_q             <= 1'b0;
			ratio_q                 <= pca_pkg::FULL_PCT;
			duty_out_q              <= '0;
		end else begin
			if (!(loop_demand && loop_error_pct > pca_pkg::LOOP_ERR_PCT))
				loop_ms_q <= 18'h00000;
			else if (ms_tick && !loop_hit)
				loop_ms_q <= loop_ms_q + 18'h00001;
			if (t_max > sink_warning_temperature)
				pre_q <= 1'b1;
			else if (9'(t_max) + pca_pkg::PRE_HYST_C <= 9'(sink_warning_temperature))
				pre_q <= 1'b0;
			phase_imbalance_alarm_q <= phase_count == 2'h3 && i_max != 10'h000
				&& 18'(i_max - i_min) * 18'h64
				>= 18'(phase_imbalance_limit) * 18'(i_max);
			ovc_q <= 10'(i_max) >= 10'(load_current_warning_limit);
			over_shed_q <= lm_master && real_delivered_power >= requested_shed_power;
			if (requested_shed_power >= total_demand_power)
				ratio_q <= pca_pkg::FULL_PCT;
			else
				ratio_q <= 7'((40'(requested_shed_power) * 40'h64)
					/ 40'(total_demand_power));
			for (int c = 0; c < pca_pkg::CH_N; c++)
				duty_out_q[c] <= 8'((16'(duty_in[c]) * 16'(coeff[c])) / 16'h64);
		end
	end

	// alarm latching and firing gate
	logic [8:0] trig;
	logic [8:0] latched_q;
	logic [8:0] active_q;
	logic [2:0] fire_q;
	logic [2:0] standby_q;
	logic       proc_stop;
	// bit order follows the alarm positions, tlf in bit 0
	assign trig = {over_shed_q, ovc_q, phase_imbalance_alarm_q, |partial_load_loss_alarm_q,
		loop_hit, pre_q, |mains_volt_q, chop_q == pca_pkg::CH_LOCK, |total_load_loss_alarm_q};
	// indication alarms sit above the stop mask and can never gate firing
	assign proc_stop = |((trig[6:0] | latched_q[6:0]) & stop_en_q);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			latched_q <= 9'h000;
			active_q  <= 9'h000;
			fire_q    <= 3'h0;
			standby_q <= 3'h7;
		end else begin
			for (int i = 0; i < pca_pkg::ALM_N; i++) begin
				if (trig[i] && latch_en_q[i])
					latched_q[i] <= 1'b1;
				else if (ack_p[i] && !trig[i])
					latched_q[i] <= 1'b0;
			end
			active_q  <= trig | latched_q;
			standby_q <= standby_ph;
			fire_q    <= ~standby_ph & {3{!proc_stop && chop_q == pca_pkg::CH_RUN}};
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 32'h0;
		end else if (reg_re) begin
			case (reg_addr)
				pca_pkg::REG_STOP_EN: rdata_q <= {25'h0, stop_en_q};
				pca_pkg::REG_LATCH_EN: rdata_q <= {23'h0, latch_en_q};
				pca_pkg::REG_ACTIVE: rdata_q <= {23'h0, active_q};
				pca_pkg::REG_LATCHED: rdata_q <= {23'h0, latched_q};
				pca_pkg::REG_SYS: rdata_q <= {17'h0, fire_q, 1'b0, !rail_s2_q, freq_q,
					dip_q, over_temp_q, supply_absent_alarm};
				pca_pkg::REG_LIM0: rdata_q <= lim0_q;
				pca_pkg::REG_LIM1: rdata_q <= lim1_q;
				pca_pkg::REG_CFG: rdata_q <= cfg_q;
				pca_pkg::REG_SHED: rdata_q <= shed_q;
				pca_pkg::REG_NOM: rdata_q <= nom_q;
				default: rdata_q <= 32'h0;
			endcase
		end else begin
			rdata_q <= 32'h0;
		end
	end

	assign reg_rdata = rdata_q;
	assign duty_out = duty_out_q;
	assign fire_enable = fire_q;
	assign standby = standby_q;
	assign alarm_active = active_q;
	assign alarm_latched = latched_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_rail_stop: assert property (!rail_s2_q |=> fire_enable == 3'h0)
		else $error("firing while rail failed");
	a_multi_standby: assert property (multi && (|supply_absent_alarm) |=> fire_enable == 3'h0)
		else $error("multi-phase fired with a phase missing");
	a_sys_standby: assert property (standby_ph[0] |=> !fire_enable[0] && standby[0])
		else $error("system alarm did not force standby");
	a_ack_ignored: assert property ((latched_q & trig) != 9'h000
		|=> (latched_q & $past(latched_q & trig)) == $past(latched_q & trig))
		else $error("latched alarm cleared while trigger active");
	a_latch_hold: assert property (##1 (latched_q & $past(latched_q & ~ack_p))
		== $past(latched_q & ~ack_p))
		else $error("latched alarm dropped without acknowledge");
	a_chop_pause: assert property (chop_q == pca_pkg::CH_RUN && over_rise && !lock_set
		|=> chop_q == pca_pkg::CH_PAUSE ##1 fire_enable == 3'h0)
		else $error("threshold crossing did not pause firing");
	a_chop_lock: assert property (chop_q == pca_pkg::CH_LOCK && over
		|=> chop_q == pca_pkg::CH_LOCK)
		else $error("chop lock left while current over limit");
	a_plf_tlf: assert property ((partial_load_loss_alarm_q & total_load_loss_alarm_q) == 3'h0)
		else $error("partial failure alongside total loss");
	a_freq_range: assert property (freq_strobe && mains_freq < pca_pkg::F_MIN
		|=> freq_q ##1 fire_enable == 3'h0)
		else $error("low frequency not flagged");
	a_shed_none: assert property (requested_shed_power >= total_demand_power
		|=> ratio_q == pca_pkg::FULL_PCT)
		else $error("reduction applied with shed above demand");
	// two cycles off master, so a flag computed while still master has drained
	a_shed_slave: assert property (!lm_master ##1 !lm_master
		|=> !alarm_active[pca_pkg::A_SHED] || $past(latched_q[pca_pkg::A_SHED]))
		else $error("over-shedding raised off master");
	a_indic_free: assert property (stop_en_q == 7'h00 && chop_q == pca_pkg::CH_RUN
		&& standby_ph == 3'h0 |=> fire_enable == 3'h7)
		else $error("indication alarm stopped firing");
endmodule : pca_alarm_supervisor
`default_nettype wire

// ---- shared/pca_pkg.sv ----
`default_nettype none
package pca_pkg;
	localparam int PH_N = 3;
	localparam int CH_N = 4;
	localparam int ALM_N = 9;
	localparam int PROC_N = 7;
	// alarm bit positions
	localparam int A_TLF = 0;
	localparam int A_CHOP = 1;
	localparam int A_MV = 2;
	localparam int A_PRE = 3;
	localparam int A_LOOP = 4;
	localparam int A_PLF = 5;
	localparam int A_PLU = 6;
	localparam int A_OVC = 7;
	localparam int A_SHED = 8;
	// register byte offsets
	localparam logic [7:0] REG_STOP_EN = 8'h00;
	localparam logic [7:0] REG_LATCH_EN = 8'h04;
	localparam logic [7:0] REG_ACK = 8'h08;
	localparam logic [7:0] REG_ACTIVE = 8'h0c;
	localparam logic [7:0] REG_LATCHED = 8'h10;
	localparam logic [7:0] REG_SYS = 8'h14;
	localparam logic [7:0] REG_LIM0 = 8'h18;
	localparam logic [7:0] REG_LIM1 = 8'h1c;
	localparam logic [7:0] REG_CFG = 8'h20;
	localparam logic [7:0] REG_SHED = 8'h24;
	localparam logic [7:0] REG_NOM = 8'h28;
	localparam logic [7:0] REG_CAPTURE = 8'h2c;
	// values after reset
	localparam logic [6:0] STOP_EN_RST = 7'h7f;
	localparam logic [8:0] LATCH_EN_RST = 9'h000;
	localparam logic [31:0] LIM0_RST = 32'h556e5a14;
	localparam logic [31:0] LIM1_RST = 32'h44780064;
	localparam logic [31:0] CFG_RST = 32'h1314003c;
	localparam logic [31:0] SHED_RST = 32'h00000000;
	localparam logic [31:0] NOM_RST = 32'h03e80190;
	// field positions
	localparam int L0_DIP = 0;
	localparam int L0_PRE = 8;
	localparam int L0_HIGH = 16;
	localparam int L0_LOW = 24;
	localparam int L1_WARN = 0;
	localparam int L1_SUST = 16;
	localparam int L1_CNT = 24;
	localparam int L1_DIV = 29;
	localparam int CF_WIN = 0;
	localparam int CF_IMB = 16;
	localparam int CF_PHASES = 24;
	localparam int CF_MASTER = 26;
	localparam int CF_BASE60 = 27;
	localparam int CF_REPEAT = 28;
	localparam int NM_VNOM = 0;
	localparam int NM_TI = 16;
	// timing
	localparam int CLK_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES_DFLT = MS_NS / CLK_NS;
	localparam int SEC_MS = 1000;
	localparam int CHOP_SUSTAIN_S = 5;
	localparam logic [12:0] CHOP_SUSTAIN_MS = 13'(CHOP_SUSTAIN_S * SEC_MS);
	localparam logic [6:0] CHOP_PAUSE_MS = 7'h64;
	// mains frequency in 0.01 Hz
	localparam logic [15:0] F_MIN = 16'h125c;
	localparam logic [15:0] F_MAX = 16'h189c;
	localparam logic [15:0] F_BASE50 = 16'h1388;
	localparam logic [15:0] F_BASE60 = 16'h1770;
	localparam logic [29:0] F_BASE_PER_10K = 30'h12;
	localparam logic [29:0] F_LAST_PER_1K = 30'h9;
	// temperatures, loop, load loss
	localparam logic [7:0] OT_TRIP_C = 8'h73;
	localparam logic [7:0] OT_CLEAR_C = 8'h69;
	localparam logic [8:0] PRE_HYST_C = 9'h002;
	localparam logic [7:0] LOOP_ERR_PCT = 8'h0a;
	localparam int LOOP_TI_MULT = 2;
	localparam logic [24:0] TLF_V_PCT = 25'h14;
	localparam logic [9:0] TLF_I_PCT = 10'h005;
	localparam logic [6:0] FULL_PCT = 7'h64;
	typedef enum logic [1:0] {CH_RUN, CH_PAUSE, CH_LOCK} pca_chop_e;
endpackage : pca_pkg
`default_nettype wire

// ---- sim/pca_alarm_supervisor_tb_top.sv ----
`default_nettype none
module pca_alarm_supervisor_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk = 1'b0;
	logic             rstn = 1'b0;
	logic [7:0]       reg_addr = 8'h00;
	logic [31:0]      reg_wdata = 32'h0;
	logic             reg_we = 1'b0;
	logic             reg_re = 1'b0;
	logic [31:0]      reg_rdata;
	logic             meas_strobe = 1'b0;
	logic             freq_strobe = 1'b0;
	logic [2:0]       supply_present = 3'h7;
	logic [2:0][15:0] line_v = {3{16'h0190}};
	logic [2:0][15:0] load_v = '0;
	logic [2:0][9:0]  load_i_pct = {3{10'h032}};
	logic [2:0][15:0] load_z = {3{16'h0064}};
	logic [2:0][7:0]  sink_temp = {3{8'h28}};
	logic [15:0]      mains_freq = 16'h1388;
	logic             rail_24v_ok = 1'b1;
	logic             loop_demand = 1'b0;
	logic [7:0]       loop_error_pct = 8'h00;
	logic [31:0]      requested_shed_power = 32'h64;
	logic [31:0]      total_demand_power = 32'h64;
	logic [31:0]      real_delivered_power = 32'h0;
	logic [3:0][7:0]  duty_in = {4{8'hc8}};
	logic [3:0][7:0]  duty_out;
	logic [2:0]       fire_enable;
	logic [2:0]       standby;
	logic [8:0]       alarm_active;
	logic [8:0]       alarm_latched;
	int               fails = 0;
	int               checks = 0;
	int               cyc = 0;
	// short millisecond keeps the chop timers inside the run
	pca_alarm_supervisor #(.MS_CYCLES(2)) i_pca_alarm_supervisor (.*);
	always #2 clk = ~clk;
	task automatic stop_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_bit(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chk_bit
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd
	// level inputs settle through sync and output registers
	task automatic pulse();
		@(posedge clk);
		meas_strobe <= 1'b1;
		freq_strobe <= 1'b1;
		@(posedge clk);
		meas_strobe <= 1'b0;
		freq_strobe <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask : pulse
	task automatic fire(input logic [15:0] f, input logic [2:0] e);
		mains_freq <= f;
		pulse();
		chk({29'h0, fire_enable}, {29'h0, e});
	endtask : fire
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd(pca_pkg::REG_STOP_EN, 32'h7f);
		rd(pca_pkg::REG_LIM0, pca_pkg::LIM0_RST);
		rd(pca_pkg::REG_LIM1, pca_pkg::LIM1_RST);
		rd(pca_pkg::REG_CFG, pca_pkg::CFG_RST);
		rd(pca_pkg::REG_NOM, pca_pkg::NOM_RST);
		rd(8'hfc, 32'h0);
		// process alarms stay out of the firing checks below
		wr(pca_pkg::REG_STOP_EN, 32'h0);
		fire(16'h1388, 3'h7);
		fire(16'h1391, 3'h7);
		fire(16'h139b, 3'h0);
		fire(16'h139b, 3'h7);
		fire(16'h11f8, 3'h0);
		fire(16'h11f8, 3'h0);
		fire(16'h1388, 3'h0);
		fire(16'h1388, 3'h7);
		line_v <= {3{16'h012c}};
		pulse();
		chk({29'h0, fire_enable}, 32'h0);
		chk_bit(alarm_active[pca_pkg::A_MV], 1'b1);
		pulse();
		chk({29'h0, fire_enable}, 32'h0);
		supply_present <= 3'h0;
		pulse();
		chk_bit(alarm_active[pca_pkg::A_MV], 1'b0);
		supply_present <= 3'h7;
		line_v <= {3{16'h0190}};
		fire(16'h1388, 3'h7);
		wr(pca_pkg::REG_CAPTURE, 32'h1);
		load_z <= {3{16'h00c8}};
		pulse();
		chk_bit(alarm_active[pca_pkg::A_PLF], 1'b1);
		load_v <= {3{16'h0190}};
		load_i_pct <= {3{10'h000}};
		pulse();
		chk_bit(alarm_active[pca_pkg::A_TLF], 1'b1);
		chk_bit(alarm_active[pca_pkg::A_PLF], 1'b0);
		load_z <= {3{16'h0064}};
		load_v <= '0;
		load_i_pct <= {3{10'h032}};
		load_i_pct[0] <= 10'h028;
		pulse();
		chk_bit(alarm_active[pca_pkg::A_PLU], 1'b1);
		load_i_pct[0] <= 10'h029;
		pulse();
		chk_bit(alarm_active[pca_pkg::A_PLU], 1'b0);
		load_i_pct[0] <= 10'h032;
		// five millisecond integral time keeps the loop check short
		wr(pca_pkg::REG_NOM, 32'h00050190);
		loop_demand <= 1'b1;
		loop_error_pct <= 8'h0b;
		pulse();
		chk_bit(alarm_active[pca_pkg::A_LOOP], 1'b0);
		repeat (30) @(posedge clk);
		#1;
		chk_bit(alarm_active[pca_pkg::A_LOOP], 1'b1);
		loop_error_pct <= 8'h0a;
		pulse();
		chk_bit(alarm_active[pca_pkg::A_LOOP], 1'b0);
		loop_demand <= 1'b0;
		rail_24v_ok <= 1'b0;
		fire(16'h1388, 3'h0);
		rail_24v_ok <= 1'b1;
		fire(16'h1388, 3'h7);
		supply_present <= 3'h5;
		fire(16'h1388, 3'h0);
		chk({29'h0, standby}, 32'h7);
		supply_present <= 3'h7;
		fire(16'h1388, 3'h7);
		sink_temp[2] <= 8'h74;
		pulse();
		chk_bit(fire_enable[2], 1'b0);
		chk_bit(alarm_active[pca_pkg::A_PRE], 1'b1);
		sink_temp[2] <= 8'h6e;
		pulse();
		chk_bit(fire_enable[2], 1'b0);
		chk_bit(alarm_active[pca_pkg::A_PRE], 1'b1);
		sink_temp[2] <= 8'h28;
		pulse();
		chk_bit(fire_enable[2], 1'b1);
		chk_bit(alarm_active[pca_pkg::A_PRE], 1'b0);
		wr(pca_pkg::REG_LATCH_EN, 32'h80);
		load_i_pct <= {3{10'h064}};
		fire(16'h1388, 3'h7);
		chk_bit(alarm_active[pca_pkg::A_OVC], 1'b1);
		wr(pca_pkg::REG_ACK, 32'h80);
		load_i_pct <= {3{10'h063}};
		pulse();
		chk_bit(alarm_active[pca_pkg::A_OVC], 1'b1);
		chk_bit(alarm_latched[pca_pkg::A_OVC], 1'b1);
		rd(pca_pkg::REG_LATCHED, 32'h80);
		wr(pca_pkg::REG_ACK, 32'h80);
		pulse();
		chk_bit(alarm_active[pca_pkg::A_OVC], 1'b0);
		requested_shed_power <= 32'h32;
		pulse();
		chk({24'h0, duty_out[0]}, 32'h64);
		wr(pca_pkg::REG_SHED, 32'h6400);
		pulse();
		chk({24'h0, duty_out[1]}, 32'hc8);
		chk({24'h0, duty_out[2]}, 32'h64);
		wr(pca_pkg::REG_CFG, 32'h1714003c);
		real_delivered_power <= 32'h32;
		pulse();
		chk_bit(alarm_active[pca_pkg::A_SHED], 1'b1);
		real_delivered_power <= 32'h31;
		pulse();
		chk_bit(alarm_active[pca_pkg::A_SHED], 1'b0);
		// first crossing pauses, then firing restarts after 100 ms
		load_i_pct <= {3{10'h078}};
		pulse();
		chk({29'h0, fire_enable}, 32'h0);
		repeat (210) @(posedge clk);
		#1;
		chk({29'h0, fire_enable}, 32'h7);
		// four more crossings exceed the count of four inside the window
		repeat (4) begin
			load_i_pct <= {3{10'h032}};
			@(posedge clk);
			load_i_pct <= {3{10'h078}};
			@(posedge clk);
		end
		repeat (210) @(posedge clk);
		#1;
		chk({29'h0, fire_enable}, 32'h0);
		chk_bit(alarm_active[pca_pkg::A_CHOP], 1'b1);
		wr(pca_pkg::REG_ACK, 32'h2);
		pulse();
		chk({29'h0, fire_enable}, 32'h0);
		load_i_pct <= {3{10'h032}};
		wr(pca_pkg::REG_ACK, 32'h2);
		pulse();
		chk({29'h0, fire_enable}, 32'h7);
		// repeat counting off: only the five second hold can lock
		wr(pca_pkg::REG_CFG, 32'h0714003c);
		load_i_pct <= {3{10'h078}};
		repeat (300) @(posedge clk);
		#1;
		chk({29'h0, fire_enable}, 32'h7);
		repeat (9600) @(posedge clk);
		#1;
		chk({29'h0, fire_enable}, 32'h7);
		repeat (150) @(posedge clk);
		#1;
		chk({29'h0, fire_enable}, 32'h0);
		stop_test();
	end
endmodule : pca_alarm_supervisor_tb_top
`default_nettype wire
